// ---- bench/canmb_peer.sv ----
// Protocol controller model: bus idle, arbitration and frame end
`timescale 1ns/1ps
`default_nettype none
module canmb_peer (
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic tx_busy_i,
    input  wire logic idle_en_i,
    input  wire logic lose_i,
    input  wire logic slow_i,
    output logic      bus_idle_o,
    output logic      arb_lost_o,
    output logic      tx_done_o
);
    logic lost_r = 1'b0;
    logic done_r = 1'b0;
    int   cnt    = 0;
    // Idle only while none of our frames is on the wire
    assign bus_idle_o = idle_en_i & ~tx_busy_i;
    assign arb_lost_o = lost_r;
    assign tx_done_o  = done_r;
    ////////////////////////////////////////////////////////////////////
    // Frame ends after a short or long stretch, lost only when told
    always @(negedge clock_i)
    begin
        lost_r <= 1'b0;
        done_r <= 1'b0;
        if (srst_i || !tx_busy_i || lost_r || done_r)
            cnt <= 0;
        else if (cnt == (slow_i ? 9 : 2))
        begin
            lost_r <= lose_i;
            done_r <= !lose_i;
            cnt    <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the mailbox controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import canmb_pkg::*;
    logic                clock_i    = 1'b0;
    logic                srst_i     = 1'b1;
    logic                sw_wr_i    = 1'b0;
    logic [IDX_W-1:0]    sw_idx_i   = '0;
    logic                sw_dir_i   = 1'b0;
    logic                sw_ide_i   = 1'b0;
    logic [EXT_ID_W-1:0] sw_id_i    = '0;
    logic [DLC_W-1:0]    sw_dlc_i   = '0;
    logic [DATA_W-1:0]   sw_data_i  = '0;
    logic                sw_free_i  = 1'b0;
    logic [IDX_W-1:0]    rd_idx_i   = '0;
    logic                rx_valid_i = 1'b0;
    logic                rx_ide_i   = 1'b0;
    logic [EXT_ID_W-1:0] rx_id_i    = '0;
    logic [DLC_W-1:0]    rx_dlc_i   = '0;
    logic [DATA_W-1:0]   rx_data_i  = '0;
    logic                idle_en    = 1'b0;
    logic                lose       = 1'b0;
    logic                slow       = 1'b0;
    logic                rd_dir_o, rd_ide_o, rd_full_o, rd_pend_o;
    logic [EXT_ID_W-1:0] rd_id_o, tx_id_o;
    logic [DLC_W-1:0]    rd_dlc_o, tx_dlc_o;
    logic [DATA_W-1:0]   rd_data_o, tx_data_o;
    logic [IDX_W-1:0]    tx_mb_o;
    logic                tx_start_o, tx_busy_o, tx_ide_o, rx_ready_o;
    logic                bus_idle_i, arb_lost_i, tx_done_i;
    int                  fails      = 0;
    int                  n_compared = 0;

    always #5 clock_i = ~clock_i;

    canmb_mailbox i_dut (
        .clock_i(clock_i), .srst_i(srst_i), .sw_wr_i(sw_wr_i),
        .sw_idx_i(sw_idx_i), .sw_dir_i(sw_dir_i), .sw_ide_i(sw_ide_i),
        .sw_id_i(sw_id_i), .sw_dlc_i(sw_dlc_i), .sw_data_i(sw_data_i),
        .sw_free_i(sw_free_i), .rd_idx_i(rd_idx_i), .rd_dir_o(rd_dir_o),
        .rd_ide_o(rd_ide_o), .rd_id_o(rd_id_o), .rd_dlc_o(rd_dlc_o),
        .rd_data_o(rd_data_o), .rd_full_o(rd_full_o), .rd_pend_o(rd_pend_o),
        .bus_idle_i(bus_idle_i), .arb_lost_i(arb_lost_i),
        .tx_done_i(tx_done_i), .tx_start_o(tx_start_o),
        .tx_busy_o(tx_busy_o), .tx_mb_o(tx_mb_o), .tx_ide_o(tx_ide_o),
        .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o), .tx_data_o(tx_data_o),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .rx_ide_i(rx_ide_i), .rx_id_i(rx_id_i), .rx_dlc_i(rx_dlc_i),
        .rx_data_i(rx_data_i));
    canmb_peer i_peer (
        .clock_i(clock_i), .srst_i(srst_i), .tx_busy_i(tx_busy_o),
        .idle_en_i(idle_en), .lose_i(lose), .slow_i(slow),
        .bus_idle_o(bus_idle_i), .arb_lost_o(arb_lost_i),
        .tx_done_o(tx_done_i));

    ////////////////////////////////////////////////////////////////////
    // Checking and closing
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic give_up(input string what);
        fails++;
        $display("wrong value %s: expected event, seen none", what);
        report_and_stop();
    endtask
    // Standard mailboxes keep only the low eleven identifier bits
    function automatic logic [EXT_ID_W-1:0] exp_id(input logic ide,
                                                  input logic [28:0] id);
        return ide ? id : {18'h0, id[STD_ID_W-1:0]};
    endfunction
    // Low nibble doubles as the length code, kept within 0..8
    function automatic logic [DATA_W-1:0] rnd_data();
        logic [DATA_W-1:0] d;
        d = {$urandom, $urandom};
        d[3:0] = 4'($urandom_range(8));
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Port tasks, all driven from the falling edge
    task automatic tick();
        @(negedge clock_i);
    endtask
    task automatic do_reset();
        srst_i = 1'b1;
        repeat (10) tick();
        srst_i = 1'b0;
    endtask
    task automatic wr(input logic [4:0] idx, input logic dir, ide,
                      input logic [28:0] id, input logic [63:0] d);
        sw_idx_i  = idx;
        sw_dir_i  = dir;
        sw_ide_i  = ide;
        sw_id_i   = id;
        sw_dlc_i  = d[3:0];
        sw_data_i = d;
        sw_wr_i   = 1'b1;
        tick();
        sw_wr_i   = 1'b0;
        tick();
    endtask
    task automatic rd_chk(input logic [4:0] idx, input logic dir, ide,
                          input logic [28:0] id, input logic [63:0] d,
                          input logic full, pend);
        rd_idx_i = idx;
        tick();
        tick();
        check("dir", rd_dir_o, dir);
        check("ide", rd_ide_o, ide);
        check("id", rd_id_o, exp_id(ide, id));
        check("dlc", rd_dlc_o, d[3:0]);
        check("data", rd_data_o, d);
        check("full", rd_full_o, full);
        check("pend", rd_pend_o, pend);
    endtask
    task automatic wait_tx(input logic [4:0] mb, input logic ide,
                           input logic [28:0] id, input logic [63:0] d,
                           input logic stop_idle);
        int i;
        for (i = 0; i < 300 && tx_start_o !== 1'b1; i++)
            tick();
        if (i == 300)
            give_up("tx start");
        idle_en = !stop_idle;
        check("tx mb", tx_mb_o, mb);
        check("tx id", tx_id_o, exp_id(ide, id));
        check("tx ide", tx_ide_o, ide);
        check("tx data", tx_data_o, d);
        check("tx dlc", tx_dlc_o, d[3:0]);
        tick();
        check("tx start pulse", tx_start_o, 1'b0);
        check("tx busy", tx_busy_o, 1'b1);
        for (i = 0; i < 300 && tx_busy_o !== 1'b0; i++)
            tick();
        if (i == 300)
            give_up("tx end");
    endtask
    task automatic rx_send(input logic ide, input logic [28:0] id,
                           input logic [63:0] d);
        int i;
        rx_ide_i   = ide;
        rx_id_i    = id;
        rx_dlc_i   = d[3:0];
        rx_data_i  = d;
        rx_valid_i = 1'b1;
        for (i = 0; i < 100 && rx_ready_o !== 1'b1; i++)
            tick();
        if (i == 100)
            give_up("rx ready");
        tick();
        rx_valid_i = 1'b0;
        rx_data_i  = ~d;
        tick();
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        logic [28:0] ia, ib;
        logic [63:0] da, db;
        logic        dir;
        int          k, n;
        void'($urandom(32'hff80));
        do_reset();
        rd_chk(5'($urandom), 0, 0, '0, '0, 0, 0);
        check("rx ready", rx_ready_o, 1'b1);
        // Two pending boundary mailboxes, sent unprompted, lowest first
        ia = $urandom;
        ib = $urandom;
        da = rnd_data();
        db = rnd_data();
        wr(31, DIR_TX, 1, ia, da);
        wr(0, DIR_TX, 0, ib, db);
        rd_chk(0, DIR_TX, 0, ib, db, 0, 1);
        idle_en = 1'b1;
        wait_tx(0, 0, ib, db, 0);
        wait_tx(31, 1, ia, da, 1);
        rd_chk(31, DIR_TX, 1, ia, da, 0, 0);
        // Lost arbitration keeps the frame pending, retried at next idle
        lose = 1'b1;
        slow = 1'b1;
        idle_en = 1'b1;
        wr(5, DIR_TX, 0, ib, db);
        wait_tx(5, 0, ib, db, 1);
        rd_chk(5, DIR_TX, 0, ib, db, 0, 1);
        lose = 1'b0;
        idle_en = 1'b1;
        wait_tx(5, 0, ib, db, 1);
        rd_chk(5, DIR_TX, 0, ib, db, 0, 0);
        // Duplicate receive identifiers: only the lower mailbox fills
        do_reset();
        ib = {18'h0, 11'($urandom)};
        wr(20, DIR_RX, 0, ib, '0);
        wr(10, DIR_RX, 0, ib, '0);
        wr(4, DIR_RX, 1, ia, '0);
        rx_send(0, ib, da);
        rx_send(1, ia, db);
        rx_send(0, ib ^ 29'h1, db);
        rd_chk(10, DIR_RX, 0, ib, da, 1, 0);
        rd_chk(20, DIR_RX, 0, ib, '0, 0, 0);
        rd_chk(4, DIR_RX, 1, ia, db, 1, 0);
        sw_free_i = 1'b1;
        tick();
        sw_free_i = 1'b0;
        rd_chk(4, DIR_RX, 1, ia, db, 0, 0);
        // Buffer fills while software writes stall the drain
        wr(2, DIR_RX, 0, ib, '0);
        sw_idx_i   = 5'd31;
        sw_wr_i    = 1'b1;
        rx_valid_i = 1'b1;
        rx_ide_i   = 1'b0;
        rx_id_i    = ib;
        rx_dlc_i   = '0;
        n = 0;
        for (k = 0; k < 12; k++)
        begin
            rx_data_i = 64'(k) << 8;
            if (rx_ready_o === 1'b1)
                n++;
            tick();
        end
        check("takes", 64'(n), 64'(FIFO_DEP));
        check("rx ready full", rx_ready_o, 1'b0);
        rx_valid_i = 1'b0;
        sw_wr_i    = 1'b0;
        rd_idx_i   = 5'd2;
        da = 64'(FIFO_DEP - 1) << 8;
        for (k = 0; k < 60 && rd_data_o !== da; k++)
            tick();
        if (k == 60)
            give_up("rx drain");
        rd_chk(2, DIR_RX, 0, ib, da, 1, 0);
        // Sixteen random frames, each into a random mailbox flipped between directions
        do_reset();
        idle_en = 1'b0;
        for (k = 0; k < 16; k++)
        begin
            ib  = $urandom;
            db  = rnd_data();
            dir = 1'($urandom);
            rd_idx_i = 5'($urandom);
            wr(rd_idx_i, dir, ib[0], ib, db);
            rd_chk(rd_idx_i, dir, ib[0], ib, db, 0, dir);
            wr(rd_idx_i, !dir, ib[1], ib, db);
            rd_chk(rd_idx_i, !dir, ib[1], ib, db, 0, !dir);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// ---- hw/canmb_mailbox.sv ----
// Mailbox array with transmit selection, receive buffer and receive fill
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Receive buffer: registered flags so in_ready_o and out_valid_o come from flip-flops
module canmb_fifo
    import canmb_pkg::*;
#(
    parameter int WIDTH = RXW_W,
    parameter int DEPTH = FIFO_DEP
)(
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    // Refuse depths that the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_bad_depth
        $error("canmb_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0]      cnt_r, cnt_nxt;
    logic             room_r, room_nxt, empty_r, empty_nxt;
    logic             push, pop;

    // Pointer and level update
    always_comb
    begin
        push      = in_valid_i && room_r;
        pop       = out_ready_i && !empty_r;
        wp_nxt    = push ? wp_r + 1'b1 : wp_r;
        rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt   = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        room_nxt  = (cnt_nxt != (PW+1)'(DEPTH));
        empty_nxt = (cnt_nxt == '0);
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            wp_r    <= '0;
            rp_r    <= '0;
            cnt_r   <= '0;
            room_r  <= 1'b1;
            empty_r <= 1'b1;
        end
        else
        begin
            wp_r    <= wp_nxt;
            rp_r    <= rp_nxt;
            cnt_r   <= cnt_nxt;
            room_r  <= room_nxt;
            empty_r <= empty_nxt;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge clock_i)
    begin
        if (push)
            mem_r[wp_r] <= in_data_i;
    end

    assign in_ready_o  = room_r;
    assign out_valid_o = !empty_r;
    assign out_data_o  = mem_r[rp_r];
endmodule

////////////////////////////////////////////////////////////////////////////
// Mailbox controller top
module canmb_mailbox
    import canmb_pkg::*;
#(
    parameter int MB_COUNT = NUM_MB
)(
    input  wire logic                 clock_i,
    input  wire logic                 srst_i,
    // Software write port
    input  wire logic                 sw_wr_i,
    input  wire logic [IDX_W-1:0]     sw_idx_i,
    input  wire logic                 sw_dir_i,
    input  wire logic                 sw_ide_i,
    input  wire logic [EXT_ID_W-1:0]  sw_id_i,
    input  wire logic [DLC_W-1:0]     sw_dlc_i,
    input  wire logic [DATA_W-1:0]    sw_data_i,
    input  wire logic                 sw_free_i,
    // Software read port, one cycle latency
    input  wire logic [IDX_W-1:0]     rd_idx_i,
    output logic                      rd_dir_o,
    output logic                      rd_ide_o,
    output logic [EXT_ID_W-1:0]       rd_id_o,
    output logic [DLC_W-1:0]          rd_dlc_o,
    output logic [DATA_W-1:0]         rd_data_o,
    output logic                      rd_full_o,
    output logic                      rd_pend_o,
    // Protocol controller transmit side
    input  wire logic                 bus_idle_i,
    input  wire logic                 arb_lost_i,
    input  wire logic                 tx_done_i,
    output logic                      tx_start_o,
    output logic                      tx_busy_o,
    output logic [IDX_W-1:0]          tx_mb_o,
    output logic                      tx_ide_o,
    output logic [EXT_ID_W-1:0]       tx_id_o,
    output logic [DLC_W-1:0]          tx_dlc_o,
    output logic [DATA_W-1:0]         tx_data_o,
    // Protocol controller receive side
    input  wire logic                 rx_valid_i,
    output logic                      rx_ready_o,
    input  wire logic                 rx_ide_i,
    input  wire logic [EXT_ID_W-1:0]  rx_id_i,
    input  wire logic [DLC_W-1:0]     rx_dlc_i,
    input  wire logic [DATA_W-1:0]    rx_data_i
);
    // Index ports are five bits wide, so no more boxes than that
    if (MB_COUNT < 1 || MB_COUNT > NUM_MB)
    begin : g_bad_count
        $error("canmb_mailbox: MB_COUNT out of range");
    end

    // Mailbox state
    logic [EXT_ID_W-1:0] id_r [MB_COUNT], id_nxt [MB_COUNT];
    logic [DLC_W-1:0]    dlc_r [MB_COUNT], dlc_nxt [MB_COUNT];
    logic [DATA_W-1:0]   dat_r [MB_COUNT], dat_nxt [MB_COUNT];
    logic [MB_COUNT-1:0] dir_r, dir_nxt, ide_r, ide_nxt;
    logic [MB_COUNT-1:0] pend_r, pend_nxt, full_r, full_nxt;
    // Transmit engine state
    canmb_tx_e           st_r, st_nxt;
    logic [IDX_W-1:0]    sel_r, sel_nxt;
    // Receive path
    logic                dq_valid, dq_ready;
    logic [RXW_W-1:0]    dq_word;
    logic [MB_COUNT-1:0] tx_cand, rx_hit;
    logic [IDX_W-1:0]    tx_low, rx_low;
    logic                rx_store;
    logic [EXT_ID_W-1:0] dq_id;
    logic                dq_ide;

    // Lowest set bit wins; bit 0 is mailbox 0
    function automatic logic [IDX_W-1:0] lowest(input logic [MB_COUNT-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = MB_COUNT - 1; i >= 0; i--)
            if (v[i])
                r = IDX_W'(i);
        return r;
    endfunction

    // Buffer absorbs bursts while software holds the array
    canmb_fifo #(
        .WIDTH (RXW_W),
        .DEPTH (FIFO_DEP)
    ) u_rxq (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   ({rx_ide_i, rx_id_i, rx_dlc_i, rx_data_i}),
        .out_valid_o (dq_valid),
        .out_ready_i (dq_ready),
        .out_data_o  (dq_word)
    );

    assign dq_id  = dq_word[RXW_ID +: EXT_ID_W];
    assign dq_ide = dq_word[RXW_IDE];

    // Candidate and match vectors
    always_comb
    begin
        for (int i = 0; i < MB_COUNT; i++)
        begin
            tx_cand[i] = pend_r[i] && (dir_r[i] == DIR_TX);
            rx_hit[i]  = (dir_r[i] == DIR_RX) && (ide_r[i] == dq_ide)
                && (dq_ide ? id_r[i] == dq_id
                           : id_r[i][STD_ID_W-1:0] == dq_id[STD_ID_W-1:0]);
        end
        tx_low = lowest(tx_cand);
        rx_low = lowest(rx_hit);
        // Software write owns the array this cycle, so the drain stalls
        dq_ready = !sw_wr_i;
        rx_store = dq_valid && dq_ready && (|rx_hit);
    end

    // Mailbox next values; unmatched frames are drained and dropped
    always_comb
    begin
        for (int i = 0; i < MB_COUNT; i++)
        begin
            id_nxt[i]  = id_r[i];
            dlc_nxt[i] = dlc_r[i];
            dat_nxt[i] = dat_r[i];
        end
        dir_nxt  = dir_r;
        ide_nxt  = ide_r;
        pend_nxt = pend_r;
        full_nxt = full_r;
        if (sw_free_i)
            full_nxt[rd_idx_i] = 1'b0;
        if (st_r == TX_SEND && tx_done_i)
            pend_nxt[sel_r] = 1'b0;
        if (sw_wr_i)
        begin
            // A write retargets the mailbox and reloads its frame
            id_nxt[sw_idx_i]  = sw_ide_i ? sw_id_i
                : {{(EXT_ID_W-STD_ID_W){1'b0}}, sw_id_i[STD_ID_W-1:0]};
            dlc_nxt[sw_idx_i]  = sw_dlc_i;
            dat_nxt[sw_idx_i]  = sw_data_i;
            dir_nxt[sw_idx_i]  = sw_dir_i;
            ide_nxt[sw_idx_i]  = sw_ide_i;
            pend_nxt[sw_idx_i] = (sw_dir_i == DIR_TX);
            full_nxt[sw_idx_i] = 1'b0;
        end
        else if (rx_store)
        begin
            // Overwrite keeps latest frame; set beats a same-cycle free
            id_nxt[rx_low]   = dq_ide ? dq_id
                : {{(EXT_ID_W-STD_ID_W){1'b0}}, dq_id[STD_ID_W-1:0]};
            dlc_nxt[rx_low]  = dq_word[RXW_DLC +: DLC_W];
            dat_nxt[rx_low]  = dq_word[RXW_DATA +: DATA_W];
            full_nxt[rx_low] = 1'b1;
        end
    end

    // Transmit engine: wait for idle, then present lowest pending box
    always_comb
    begin
        st_nxt  = st_r;
        sel_nxt = sel_r;
        unique case (st_r)
            TX_WAIT:
                if (bus_idle_i && (|tx_cand))
                begin
                    st_nxt  = TX_SEND;
                    sel_nxt = tx_low;
                end
            TX_SEND:
                if (arb_lost_i || tx_done_i)
                    st_nxt = TX_WAIT;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < MB_COUNT; i++)
            begin
                id_r[i]  <= '0;
                dlc_r[i] <= '0;
                dat_r[i] <= '0;
            end
            dir_r  <= '0;
            ide_r  <= '0;
            pend_r <= '0;
            full_r <= '0;
            st_r   <= TX_WAIT;
            sel_r  <= '0;
        end
        else
        begin
            id_r   <= id_nxt;
            dlc_r  <= dlc_nxt;
            dat_r  <= dat_nxt;
            dir_r  <= dir_nxt;
            ide_r  <= ide_nxt;
            pend_r <= pend_nxt;
            full_r <= full_nxt;
            st_r   <= st_nxt;
            sel_r  <= sel_nxt;
        end
    end

    // Registered outputs for read and transmit ports
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            {rd_dir_o, rd_ide_o, rd_full_o, rd_pend_o} <= '0;
            rd_id_o    <= '0;
            rd_dlc_o   <= '0;
            rd_data_o  <= '0;
            tx_start_o <= 1'b0;
            tx_busy_o  <= 1'b0;
            tx_mb_o    <= '0;
            tx_ide_o   <= 1'b0;
            tx_id_o    <= '0;
            tx_dlc_o   <= '0;
            tx_data_o  <= '0;
        end
        else
        begin
            rd_dir_o   <= dir_r[rd_idx_i];
            rd_ide_o   <= ide_r[rd_idx_i];
            rd_full_o  <= full_r[rd_idx_i];
            rd_pend_o  <= pend_r[rd_idx_i];
            rd_id_o    <= id_r[rd_idx_i];
            rd_dlc_o   <= dlc_r[rd_idx_i];
            rd_data_o  <= dat_r[rd_idx_i];
            tx_start_o <= (st_r == TX_WAIT) && (st_nxt == TX_SEND);
            tx_busy_o  <= (st_nxt == TX_SEND);
            tx_mb_o    <= sel_nxt;
            tx_ide_o   <= ide_r[sel_nxt];
            tx_id_o    <= id_r[sel_nxt];
            tx_dlc_o   <= dlc_r[sel_nxt];
            tx_data_o  <= dat_r[sel_nxt];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    logic [MB_COUNT-1:0] lowmask_tx;
    logic [MB_COUNT-1:0] lowmask_rx;
    assign lowmask_tx = (MB_COUNT'(1) << tx_mb_o) - MB_COUNT'(1);
    assign lowmask_rx = (MB_COUNT'(1) << rx_low) - MB_COUNT'(1);

    sequence idle_ready_s;
        st_r == TX_WAIT && bus_idle_i && (|tx_cand);
    endsequence
    sequence lost_s;
        st_r == TX_SEND && arb_lost_i && !tx_done_i && !sw_wr_i;
    endsequence

    tx_autostart_a: assert property (idle_ready_s |=> tx_start_o)
        else $error("pending frame not started at bus idle");
    arb_defer_a: assert property (lost_s |=> st_r == TX_WAIT
        && pend_r[$past(sel_r)])
        else $error("frame dropped after lost arbitration");
    rx_store_a: assert property (rx_store |=> full_r[$past(rx_low)])
        else $error("accepted frame not stored");
    tx_lowest_a: assert property (tx_start_o
        |-> ($past(tx_cand) & lowmask_tx) == '0)
        else $error("lower pending mailbox skipped");
    rx_lowest_a: assert property (rx_store
        |-> (rx_hit & lowmask_rx) == '0)
        else $error("lower matching mailbox skipped");
    rx_dup_a: assert property (rx_store |=> (full_r
        & ~$past(full_r) & ~(MB_COUNT'(1) << $past(rx_low))) == '0)
        else $error("higher duplicate mailbox received");
    std_id_a: assert property (tx_start_o && !tx_ide_o
        |-> tx_id_o[EXT_ID_W-1:STD_ID_W] == '0)
        else $error("standard identifier wider than 11 bits");
    dir_switch_a: assert property (sw_wr_i
        |=> dir_r[$past(sw_idx_i)] == $past(sw_dir_i))
        else $error("mailbox direction not switched");
    frame_hold_a: assert property (!(sw_wr_i && sw_idx_i == '0)
        && !(rx_store && rx_low == '0) |=> $stable(id_r[0])
        && $stable(dat_r[0]))
        else $error("mailbox frame changed without a writer");
    read_back_a: assert property (##1 rd_dlc_o == $past(dlc_r[rd_idx_i])
        && rd_data_o == $past(dat_r[rd_idx_i]))
        else $error("read port does not show mailbox");
endmodule

`default_nettype wire

// ---- hw/canmb_pkg.sv ----
// Constants shared by the mailbox controller and its receive buffer
// Functional notes
// - Loaded transmit mailbox sends itself at bus idle
// - Lost arbitration defers frame until next idle
// - Accepted frame stored into matching receive mailbox
// - Lowest mailbox number wins among mailboxes
// - Duplicate receive identifiers feed lowest mailbox only
// - Extended sends 29-bit identifier, standard 11-bit
// - Thirty-two mailboxes, each switchable transmit/receive
// - Mailbox holds frame until overwritten or rewritten
package canmb_pkg;
    localparam int NUM_MB    = 32;
    localparam int IDX_W     = 5;
    localparam int EXT_ID_W  = 29;
    localparam int STD_ID_W  = 11;
    localparam int DLC_W     = 4;
    localparam int DATA_W    = 64;
    localparam int FIFO_DEP  = 8;
    // Receive word layout: {ide, id, dlc, data}
    localparam int RXW_W     = 1 + EXT_ID_W + DLC_W + DATA_W;
    localparam int RXW_DATA  = 0;
    localparam int RXW_DLC   = DATA_W;
    localparam int RXW_ID    = DATA_W + DLC_W;
    localparam int RXW_IDE   = DATA_W + DLC_W + EXT_ID_W;
    localparam logic DIR_TX  = 1'b1;
    localparam logic DIR_RX  = 1'b0;

    typedef enum logic [0:0] {
        TX_WAIT = 1'b0,
        TX_SEND = 1'b1
    } canmb_tx_e;
endpackage
